// ==== common/pwm_steer_pkg.sv ====
/*
  Constants for the enhanced PWM shutdown and steering block: register
  offsets, field positions, reset values and codes.
  Assumes an 8-bit register port with byte-wide registers.
*/
package pwm_steer_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 8;
  // Register offsets
  localparam logic [7:0]  OFS_TSEL      = 8'h00;
  localparam logic [7:0]  OFS_SHUT      = 8'h01;
  localparam logic [7:0]  OFS_RSDLY     = 8'h02;
  localparam logic [7:0]  OFS_STEER     = 8'h03;
  localparam logic [7:0]  OFS_CHCTL     = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h05;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h06;
  // Reset values
  localparam logic [7:0]  RST_TSEL      = 8'h00;
  localparam logic [6:0]  RST_SHUT      = 7'h00;
  localparam logic [7:0]  RST_RSDLY     = 8'h00;
  localparam logic [4:0]  RST_STEER     = 5'h01;
  localparam logic [5:0]  RST_CHCTL     = 6'h00;
  localparam logic [2:0]  RST_IRQ       = 3'h0;
  // Shutdown control fields
  localparam int          SHUT_FLAG_BIT = 7;
  localparam int          SRC_HI        = 6;
  localparam int          SRC_LO        = 4;
  localparam int          PAIR1_HI      = 3;
  localparam int          PAIR1_LO      = 2;
  localparam int          PAIR2_HI      = 1;
  localparam int          PAIR2_LO      = 0;
  // Restart and delay fields
  localparam int          RSEN_BIT      = 7;
  localparam int          DLY_HI        = 6;
  // Steering fields
  localparam int          SYNC_BIT      = 4;
  localparam int          STEER_HI      = 3;
  // Channel control fields: config in 5:4, mode in 3:0
  localparam int          CFG_HI        = 5;
  localparam int          CFG_LO        = 4;
  localparam logic [1:0]  MODE_PWM      = 2'h3;
  localparam logic [1:0]  CFG_SINGLE    = 2'h0;
  // Timer select codes
  localparam logic [1:0]  TSEL_RSVD     = 2'h3;
  // Shutdown pin level codes
  localparam logic [1:0]  SHUT_LOW      = 2'h0;
  localparam logic [1:0]  SHUT_HIGH     = 2'h1;
  // Interrupt status bits
  localparam int          IRQ_SHUT      = 0;
  localparam int          IRQ_RESTART   = 1;
  localparam int          IRQ_STEER     = 2;
  // Instruction cycle is four clocks
  localparam logic [1:0]  ICYC_LAST     = 2'h3;
endpackage : pwm_steer_pkg

// ==== src/enhanced_pwm_shutdown_steering.sv ====
/*
  Enhanced PWM control: timer base choice for four channels, auto
  shutdown, active-edge delay and output steering of channel one.
  Assumes timer bases, comparators and the edge pin are synchronous to
  core_clk, and a register master that never issues both strobes.
*/
`timescale 1ns/1ps

// Functional notes
// - Two-bit code picks timer; 11 reserved
// - Shutdown event sets flag, holds outputs
// - Codes 001-011 select comparator sources; 000 none
// - Codes 1xx add low edge pin
// - Pair one shutdown: low, high, tri-state
// - Pair two shutdown: low, high, tri-state
// - Auto restart clears flag when source ends
// - Without restart, software clears the flag
// - Active edge delayed by instruction cycles
// - Sync set: steering changes at period start
// - Sync clear: steering at instruction boundary
// - Steering bit routes waveform with polarity
// - Steering only in PWM single mode
// - Steering resets to pin one only
// - Synced comparator waits for timer edge
// - Low mode bits select output polarity
module enhanced_pwm_shutdown_steering (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  // Timer bases
  input  wire logic [2:0]          tb_pwm_level,
  input  wire logic [2:0]          tb_period_start,
  // Shutdown sources
  input  wire logic                cmp_one_out,
  input  wire logic                cmp_two_out,
  input  wire logic [1:0]          comparator_output_sync,
  input  wire logic                sync_timer_edge,
  input  wire logic                edge_pin_level,
  // Channel waveforms
  output logic      [3:0]          chan_pwm,
  output logic      [3:0]          chan_period,
  // Output pins, bit 0 is output one
  output logic      [3:0]          pin_level,
  output logic      [3:0]          pin_oe,
  output logic      [3:0]          pin_steered,
  // Interrupt
  output logic                     irq
);

  logic [1:0] rst_sync_r;
  logic       rst_n_sync;
  logic [7:0] tsel_r;
  logic [6:0] shut_cfg_r;
  logic       flag_r;
  logic       flag_nxt;
  logic [7:0] rsdly_r;
  logic [4:0] steer_r;
  logic [3:0] steer_live_r;
  logic [5:0] chctl_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_set;
  logic [1:0] icyc_r;
  logic       icyc_tick;
  logic [1:0] cmp_held_r;
  logic [1:0] cmp_eff;
  logic       src_active;
  logic       wr_shut;
  logic       raw_d_r;
  logic       active_r;
  logic       dly_busy_r;
  logic [6:0] dly_cnt_r;
  logic       honour;
  logic       steer_apply;
  logic [3:0] pol_inv;
  logic [7:0] rd_nxt;

  // Two-flop reset release
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_r[1];

  // Instruction cycle divider
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      icyc_r <= 2'h0;
    end else begin
      icyc_r <= icyc_r + 2'h1;
    end
  end
  assign icyc_tick = (icyc_r == pwm_steer_pkg::ICYC_LAST);

  // Register writes
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      tsel_r     <= pwm_steer_pkg::RST_TSEL;
      shut_cfg_r <= pwm_steer_pkg::RST_SHUT;
      rsdly_r    <= pwm_steer_pkg::RST_RSDLY;
      steer_r    <= pwm_steer_pkg::RST_STEER;
      chctl_r    <= pwm_steer_pkg::RST_CHCTL;
      irq_mask_r <= pwm_steer_pkg::RST_IRQ;
    end else if (reg_wr) begin
      unique case (reg_addr)
        pwm_steer_pkg::OFS_TSEL:     tsel_r     <= reg_wdata;
        pwm_steer_pkg::OFS_SHUT:     shut_cfg_r <= reg_wdata[6:0];
        pwm_steer_pkg::OFS_RSDLY:    rsdly_r    <= reg_wdata;
        pwm_steer_pkg::OFS_STEER:    steer_r    <= reg_wdata[4:0];
        pwm_steer_pkg::OFS_CHCTL:    chctl_r    <= reg_wdata[5:0];
        pwm_steer_pkg::OFS_IRQ_MASK: irq_mask_r <= reg_wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Per-channel timer base selection, reserved code gives idle low
  generate
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          chan_pwm[ch]    <= 1'b0;
          chan_period[ch] <= 1'b0;
        end else if (tsel_r[2*ch+:2] == pwm_steer_pkg::TSEL_RSVD) begin
          chan_pwm[ch]    <= 1'b0;
          chan_period[ch] <= 1'b0;
        end else begin
          chan_pwm[ch]    <= tb_pwm_level[tsel_r[2*ch+:2]];
          chan_period[ch] <= tb_period_start[tsel_r[2*ch+:2]];
        end
      end
    end
  endgenerate

  // Comparators held until the sync timer edge when synchronised
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cmp_held_r <= 2'h0;
    end else if (sync_timer_edge) begin
      cmp_held_r <= {cmp_two_out, cmp_one_out};
    end
  end
  assign cmp_eff[0] = comparator_output_sync[0] ? cmp_held_r[0] : cmp_one_out;
  assign cmp_eff[1] = comparator_output_sync[1] ? cmp_held_r[1] : cmp_two_out;

  // Shutdown source decode
  always_comb begin
    src_active = 1'b0;
    unique case (shut_cfg_r[pwm_steer_pkg::SRC_HI:pwm_steer_pkg::SRC_LO])
      3'h0: src_active = 1'b0;
      3'h1: src_active = cmp_eff[0];
      3'h2: src_active = cmp_eff[1];
      3'h3: src_active = cmp_eff[0] | cmp_eff[1];
      3'h4: src_active = !edge_pin_level;
      3'h5: src_active = !edge_pin_level | cmp_eff[0];
      3'h6: src_active = !edge_pin_level | cmp_eff[1];
      3'h7: src_active = !edge_pin_level | cmp_eff[0] | cmp_eff[1];
    endcase
  end

  // Shutdown flag; a live source always wins
  assign wr_shut = reg_wr && (reg_addr == pwm_steer_pkg::OFS_SHUT);
  always_comb begin
    flag_nxt = flag_r;
    if (wr_shut) begin
      flag_nxt = reg_wdata[pwm_steer_pkg::SHUT_FLAG_BIT];
    end
    if (flag_r && rsdly_r[pwm_steer_pkg::RSEN_BIT] && !src_active) begin
      flag_nxt = 1'b0;
    end
    if (src_active) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Active-edge delay on channel one, counted in instruction cycles
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      raw_d_r    <= 1'b0;
      active_r   <= 1'b0;
      dly_busy_r <= 1'b0;
      dly_cnt_r  <= 7'h00;
    end else begin
      raw_d_r <= chan_pwm[0];
      if (!chan_pwm[0]) begin
        active_r   <= 1'b0;
        dly_busy_r <= 1'b0;
      end else if (!raw_d_r) begin
        if (rsdly_r[pwm_steer_pkg::DLY_HI:0] == 7'h00) begin
          active_r <= 1'b1;
        end else begin
          dly_cnt_r  <= rsdly_r[pwm_steer_pkg::DLY_HI:0];
          dly_busy_r <= 1'b1;
        end
      end else if (dly_busy_r && icyc_tick) begin
        if (dly_cnt_r == 7'h01) begin
          active_r   <= 1'b1;
          dly_busy_r <= 1'b0;
        end else begin
          dly_cnt_r <= dly_cnt_r - 7'h01;
        end
      end
    end
  end

  // Steering update point
  always_comb begin
    if (steer_r[pwm_steer_pkg::SYNC_BIT]) begin
      steer_apply = chan_period[0];
    end else begin
      steer_apply = icyc_tick;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      steer_live_r <= pwm_steer_pkg::RST_STEER[3:0];
    end else if (steer_apply) begin
      steer_live_r <= steer_r[pwm_steer_pkg::STEER_HI:0];
    end
  end

  // Mode gate and polarity
  assign honour = (chctl_r[3:2] == pwm_steer_pkg::MODE_PWM) &&
                  (chctl_r[pwm_steer_pkg::CFG_HI:pwm_steer_pkg::CFG_LO]
                   == pwm_steer_pkg::CFG_SINGLE);
  assign pol_inv = {chctl_r[0], chctl_r[1], chctl_r[0], chctl_r[1]};

  // Pin drive; pins one and three are pair one
  generate
    for (genvar p = 0; p < 4; p++) begin : g_pin
      localparam int HI = (p % 2 == 0) ? pwm_steer_pkg::PAIR1_HI : pwm_steer_pkg::PAIR2_HI;
      localparam int LO = (p % 2 == 0) ? pwm_steer_pkg::PAIR1_LO : pwm_steer_pkg::PAIR2_LO;
      always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          pin_level[p]   <= 1'b0;
          pin_oe[p]      <= 1'b0;
          pin_steered[p] <= 1'b0;
        end else if (!(honour && steer_live_r[p])) begin
          pin_level[p]   <= 1'b0;
          pin_oe[p]      <= 1'b0;
          pin_steered[p] <= 1'b0;
        end else if (flag_r) begin
          pin_steered[p] <= 1'b1;
          pin_oe[p]      <= !shut_cfg_r[HI];
          pin_level[p]   <= (shut_cfg_r[HI:LO] == pwm_steer_pkg::SHUT_HIGH);
        end else begin
          pin_steered[p] <= 1'b1;
          pin_oe[p]      <= 1'b1;
          pin_level[p]   <= active_r ^ pol_inv[p];
        end
      end
    end
  endgenerate

  // Interrupt status; events win over read-clear
  assign irq_set[pwm_steer_pkg::IRQ_SHUT]    = flag_nxt && !flag_r;
  assign irq_set[pwm_steer_pkg::IRQ_RESTART] = flag_r && !flag_nxt;
  assign irq_set[pwm_steer_pkg::IRQ_STEER]   = steer_apply &&
                        (steer_live_r != steer_r[pwm_steer_pkg::STEER_HI:0]);

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      irq_stat_r <= pwm_steer_pkg::RST_IRQ;
    end else if (reg_rd && reg_addr == pwm_steer_pkg::OFS_IRQ_STAT) begin
      irq_stat_r <= irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_r | irq_set) & irq_mask_r);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    rd_nxt = 8'h00;
    unique case (reg_addr)
      pwm_steer_pkg::OFS_TSEL:     rd_nxt = tsel_r;
      pwm_steer_pkg::OFS_SHUT:     rd_nxt = {flag_r, shut_cfg_r};
      pwm_steer_pkg::OFS_RSDLY:    rd_nxt = rsdly_r;
      pwm_steer_pkg::OFS_STEER:    rd_nxt = {3'h0, steer_r};
      pwm_steer_pkg::OFS_CHCTL:    rd_nxt = {2'h0, chctl_r};
      pwm_steer_pkg::OFS_IRQ_STAT: rd_nxt = {5'h00, irq_stat_r};
      pwm_steer_pkg::OFS_IRQ_MASK: rd_nxt = {5'h00, irq_mask_r};
      default:                     rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_sync);

  property p_tb_reserved;
    $past(tsel_r[1:0]) == 2'h3 |-> !chan_pwm[0];
  endproperty
  a_tb_reserved: assert property (p_tb_reserved) else $error("reserved timer code drove pwm");

  property p_tb_second;
    $past(tsel_r[3:2]) == 2'h1 |-> chan_pwm[1] == $past(tb_pwm_level[1]);
  endproperty
  a_tb_second: assert property (p_tb_second) else $error("timer two not followed");

  property p_shut_low;
    flag_r && honour && steer_live_r[0] && shut_cfg_r[3:2] == 2'h0
      |=> pin_oe[0] && !pin_level[0];
  endproperty
  a_shut_low: assert property (p_shut_low) else $error("pair one not driven low");

  property p_shut_pair_two;
    flag_r && honour && steer_live_r[1] && shut_cfg_r[1:0] == 2'h1
      |=> pin_oe[1] && pin_level[1];
  endproperty
  a_shut_pair_two: assert property (p_shut_pair_two) else $error("pair two not high");

  property p_cmp_one;
    shut_cfg_r[6:4] == 3'h1 && !comparator_output_sync[0] && cmp_one_out |=> flag_r;
  endproperty
  a_cmp_one: assert property (p_cmp_one) else $error("comparator one missed");

  property p_edge_pin;
    shut_cfg_r[6:4] == 3'h4 && !edge_pin_level |=> flag_r;
  endproperty
  a_edge_pin: assert property (p_edge_pin) else $error("edge pin missed");

  property p_auto_restart;
    flag_r && rsdly_r[7] && !src_active |=> !flag_r;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("no auto restart");

  property p_manual_hold;
    flag_r && !rsdly_r[7] && !wr_shut |=> flag_r;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("flag dropped alone");

  property p_zero_delay;
    $rose(chan_pwm[0]) && rsdly_r[6:0] == 7'h00 |=> active_r;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay late");

  // A count of one may expire on the very next tick
  property p_delay;
    $rose(chan_pwm[0]) && rsdly_r[6:0] != 7'h00 |=> !active_r;
  endproperty
  a_delay: assert property (p_delay) else $error("edge not delayed");

  property p_delay_long;
    $rose(chan_pwm[0]) && rsdly_r[6:0] > 7'h01 |=> !active_r [*5];
  endproperty
  a_delay_long: assert property (p_delay_long) else $error("long delay cut short");

  property p_steer_sync;
    steer_r[4] && !chan_period[0] |=> $stable(steer_live_r);
  endproperty
  a_steer_sync: assert property (p_steer_sync) else $error("steering off period");

  property p_not_honoured;
    !honour |=> pin_oe == 4'h0 && pin_steered == 4'h0;
  endproperty
  a_not_honoured: assert property (p_not_honoured) else $error("steer outside pwm");

endmodule : enhanced_pwm_shutdown_steering

// ==== verif/pwm_far_side.sv ====
/*
  Far side model: three timer bases, two comparators, the edge pin and
  the comparator sync timer. Assumes bench requests land just after
  rising edges of core_clk.
*/
`timescale 1ns/1ps
module pwm_far_side (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Bench requests
  input  wire logic       run,
  input  wire logic [2:0] force_lvl,
  input  wire logic [2:0] src_req,
  input  wire logic       sync_en,
  // Toward the block
  output logic      [2:0] tb_pwm_level,
  output logic      [2:0] tb_period_start,
  output logic            cmp_one_out,
  output logic            cmp_two_out,
  output logic            edge_pin_level,
  output logic            sync_timer_edge
);
  logic [3:0] cnt_r [3];
  logic [2:0] sync_cnt_r;
  // Periods 6, 8, 10 so the bases rarely agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    for (int k = 0; k < 3; k++) begin
      if (!reset_n) begin
        cnt_r[k] <= 4'h0;
      end else if (run) begin
        cnt_r[k] <= (cnt_r[k] >= 4'(5 + 2 * k)) ? 4'h0 : cnt_r[k] + 4'h1;
      end
    end
  end
  // Halted bases show the forced level, no period pulses
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      tb_pwm_level[k]    = run ? (cnt_r[k] < 4'(2 + k)) : force_lvl[k];
      tb_period_start[k] = run && (cnt_r[k] == 4'h0);
    end
  end
  // Edge pin idles high, as if pulled up
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {edge_pin_level, cmp_two_out, cmp_one_out} <= 3'h4;
      sync_cnt_r <= 3'h0;
    end else begin
      {edge_pin_level, cmp_two_out, cmp_one_out} <= src_req ^ 3'h4;
      sync_cnt_r <= sync_cnt_r + 3'h1;
    end
  end
  assign sync_timer_edge = sync_en && (sync_cnt_r == 3'h7);
endmodule : pwm_far_side

// ==== verif/testbench.sv ====
/*
  Self-checking bench for the enhanced PWM shutdown and steering block.
  Assumes the register map and timing of the design package and notes.
*/
`timescale 1ns/1ps
module testbench;
  logic        core_clk, reset_n, reg_wr, reg_rd, run, sync_en, irq, en;
  logic        cmp_one_out, cmp_two_out, edge_pin_level, sync_timer_edge;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0]  tb_pwm_level, tb_period_start, force_lvl, src_req;
  logic [1:0]  comparator_output_sync;
  logic [3:0]  chan_pwm, chan_period, pin_level, pin_oe, pin_steered;
  logic [31:0] v;
  integer      seed = 32'h40a7;
  int          n_fail, comparisons, cyc, n, dl;

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  enhanced_pwm_shutdown_steering i_enhanced_pwm_shutdown_steering (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tb_pwm_level, .tb_period_start, .cmp_one_out, .cmp_two_out,
    .comparator_output_sync, .sync_timer_edge, .edge_pin_level, .chan_pwm,
    .chan_period, .pin_level, .pin_oe, .pin_steered, .irq);
  pwm_far_side i_pwm_far_side (
    .core_clk, .reset_n, .run, .force_lvl, .src_req, .sync_en, .tb_pwm_level,
    .tb_period_start, .cmp_one_out, .cmp_two_out, .edge_pin_level, .sync_timer_edge);

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask : rd

  // Bounded wait on steering or on pin one level
  task automatic wait_for(input logic [3:0] want, input bit lvl, output int k);
    k = 0;
    while ((lvl ? {3'h0, pin_level[0]} : pin_steered) !== want && k < 600) begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask : wait_for

  function automatic logic [7:0] rw_mask(input int a);
    case (a)
      1: return 8'h7f;
      3: return 8'h1f;
      4: return 8'h3f;
      6: return 8'h07;
      7: return 8'h00;
      default: return 8'hff;
    endcase
  endfunction : rw_mask

  function automatic logic src_on(input logic [2:0] s, input logic [2:0] i);
    return (s[2] & i[2]) | (s[1] & i[1]) | (s[0] & i[0]);
  endfunction : src_on

  // Pair one on pins one and three, pair two on two and four
  function automatic logic [7:0] shut_pins(input logic [3:0] p);
    logic a, b;
    a = p[3:2] == 2'h1;
    b = p[1:0] == 2'h1;
    return {!p[1], !p[3], !p[1], !p[3], b, a, b, a};
  endfunction : shut_pins

  function automatic logic [3:0] pol(input logic w, input logic [1:0] m);
    return {w ^ m[0], w ^ m[1], w ^ m[0], w ^ m[1]};
  endfunction : pol

  // Sampled at the falling edge, so the registered copy is known
  task automatic chan_check(input logic [7:0] t);
    logic [2:0] lv, ps;
    logic [7:0] e;
    wr(pwm_steer_pkg::OFS_TSEL, t);
    tick(2);
    repeat (20) begin
      @(negedge core_clk);
      lv = tb_pwm_level;
      ps = tb_period_start;
      for (int c = 0; c < 4; c++) begin
        e[c] = (t[2*c+:2] != 2'h3) && lv[t[2*c+:2]];
        e[c+4] = (t[2*c+:2] != 2'h3) && ps[t[2*c+:2]];
      end
      @(posedge core_clk);
      #1;
      chk({chan_period, chan_pwm}, e, "timer base");
    end
  endtask : chan_check

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    run = 1'b0;
    sync_en = 1'b0;
    force_lvl = 3'h0;
    src_req = 3'h0;
    comparator_output_sync = 2'h0;
    tick(16);
    reset_n <= 1'b1;
    tick(2);
    for (int a = 0; a < 8; a++) begin
      rd(8'(a), d);
      chk(d, a == 3 ? 8'h01 : 8'h00, "reset value");
    end
    @(posedge core_clk);
    #1;
    chk(reg_rdata, 8'h00, "read data idle");
    repeat (4) begin
      for (int a = 0; a < 8; a++) begin
        if (a == 5) continue;
        v = $random(seed);
        wr(8'(a), v[7:0] & (a == 1 ? 8'h7f : 8'hff));
        rd(8'(a), d);
        chk(d, v[7:0] & rw_mask(a), "read back");
      end
    end
    run <= 1'b1;
    for (int c = 0; c < 4; c++) chan_check({4{2'(c)}});
    repeat (4) chan_check(8'($random(seed)));
    wr(pwm_steer_pkg::OFS_CHCTL, 8'h0c);
    wr(pwm_steer_pkg::OFS_STEER, 8'h0f);
    wr(pwm_steer_pkg::OFS_RSDLY, 8'h80);
    for (int s = 0; s < 8; s++) begin
      for (int i = 0; i < 8; i++) begin
        wr(pwm_steer_pkg::OFS_SHUT, {1'b0, 3'(s), 4'h5});
        src_req <= 3'(i);
        tick(4);
        rd(pwm_steer_pkg::OFS_SHUT, d);
        chk({7'h0, d[7]}, {7'h0, src_on(3'(s), 3'(i))}, "source");
        src_req <= 3'h0;
        tick(4);
        rd(pwm_steer_pkg::OFS_SHUT, d);
        chk(d, {1'b0, 3'(s), 4'h5}, "auto restart");
      end
    end
    // Synced comparator must wait for the sync timer
    wr(pwm_steer_pkg::OFS_SHUT, 8'h10);
    comparator_output_sync <= 2'h1;
    src_req <= 3'h1;
    tick(6);
    rd(pwm_steer_pkg::OFS_SHUT, d);
    chk(d, 8'h10, "sync held");
    sync_en <= 1'b1;
    tick(10);
    rd(pwm_steer_pkg::OFS_SHUT, d);
    chk(d, 8'h90, "sync taken");
    src_req <= 3'h0;
    tick(12);
    sync_en <= 1'b0;
    comparator_output_sync <= 2'h0;
    wr(pwm_steer_pkg::OFS_RSDLY, 8'h00);
    for (int p = 0; p < 16; p++) begin
      wr(pwm_steer_pkg::OFS_IRQ_MASK, p < 8 ? 8'h01 : 8'h00);
      wr(pwm_steer_pkg::OFS_SHUT, {4'h1, 4'(p)});
      rd(pwm_steer_pkg::OFS_IRQ_STAT, d);
      chk(d & 8'h02, 8'h02, "restart status");
      src_req <= 3'h1;
      tick(5);
      chk({pin_oe, pin_level}, shut_pins(4'(p)), "shutdown pins");
      chk({7'h0, irq}, {7'h0, p < 8}, "irq raised");
      wr(pwm_steer_pkg::OFS_SHUT, {4'h1, 4'(p)});
      src_req <= 3'h0;
      tick(4);
      rd(pwm_steer_pkg::OFS_SHUT, d);
      chk(d, {4'h9, 4'(p)}, "flag kept");
      chk({pin_oe, pin_level}, shut_pins(4'(p)), "pins held");
      rd(pwm_steer_pkg::OFS_IRQ_STAT, d);
      chk(d & 8'h01, 8'h01, "status");
      tick(2);
      chk({7'h0, irq}, 8'h00, "irq cleared");
      wr(pwm_steer_pkg::OFS_SHUT, {4'h1, 4'(p)});
      tick(4);
      rd(pwm_steer_pkg::OFS_SHUT, d);
      chk({d[7], 3'h0, pin_oe}, 8'h0f, "resumed");
    end
    run <= 1'b0;
    wr(pwm_steer_pkg::OFS_TSEL, 8'h00);
    for (int k = 0; k < 16; k++) begin
      v = $random(seed);
      v[7:6] = 2'(k);
      en = v[7:6] == 2'h0 || v[7:6] == 2'h3;
      wr(pwm_steer_pkg::OFS_CHCTL,
         {2'h0, v[7:6] == 2'h1 ? 2'h1 : 2'h0, v[7:6] == 2'h2 ? 2'h2 : 2'h3, v[5:4]});
      wr(pwm_steer_pkg::OFS_STEER, {4'h0, v[3:0]});
      force_lvl <= {2'h0, v[8]};
      tick(10);
      chk({4'h0, pin_oe}, {4'h0, en ? v[3:0] : 4'h0}, "steering");
      if (en) chk({pin_steered, pin_level & v[3:0]}, {v[3:0], pol(v[8], v[5:4]) & v[3:0]},
                  "polarity");
    end
    wr(pwm_steer_pkg::OFS_CHCTL, 8'h0c);
    wr(pwm_steer_pkg::OFS_STEER, 8'h01);
    tick(8);
    rd(pwm_steer_pkg::OFS_IRQ_STAT, d);
    wr(pwm_steer_pkg::OFS_STEER, 8'h06);
    wait_for(4'h6, 1'b0, n);
    chk(8'(n <= 6), 8'h01, "steer at instruction");
    rd(pwm_steer_pkg::OFS_IRQ_STAT, d);
    chk(d & 8'h04, 8'h04, "steer status");
    wr(pwm_steer_pkg::OFS_STEER, 8'h19);
    tick(12);
    chk({4'h0, pin_steered}, 8'h06, "steer deferred");
    run <= 1'b1;
    wait_for(4'h9, 1'b0, n);
    chk(8'(n <= 10), 8'h01, "steer at period");
    run <= 1'b0;
    wr(pwm_steer_pkg::OFS_STEER, 8'h01);
    for (int k = 0; k < 7; k++) begin
      dl = k == 0 ? 0 : k == 1 ? 1 : k == 2 ? 127 : {$random(seed)} % 9;
      wr(pwm_steer_pkg::OFS_RSDLY, 8'(dl));
      force_lvl <= 3'h0;
      tick(8);
      force_lvl <= 3'h1;
      wait_for(4'h1, 1'b1, n);
      chk(8'(n >= 4 * dl - 3 && n <= (dl == 0 ? 3 : 4 * dl + 4)), 8'h01, "delay");
      force_lvl <= 3'h0;
      wait_for(4'h0, 1'b1, n);
      chk(8'(n <= 3), 8'h01, "fall");
    end
    close_out();
  end
endmodule : testbench
